// ---- verilog/dd_dac_ctrl.sv ----
// dual 10-bit converter: two-wire slave engine and channel registers
`timescale 1ns/1ps
`include "dd_params.svh"
// Function
// - address lsb follows address select pin
// - write output register directly or input only
// - codes are 10-bit straight binary
// - power-on clears outputs, powers channels down
// - two select bits choose power-down termination
// - power-down disables buffer and string
// - registers kept; wake-up restores previous output
// - slave only; master makes the clock
// - eight bit words plus acknowledge clock
// - data changes at clock high are conditions
// - start falls, stop rises, clock high
// - repeated start opens new address phase
// - idle after stop or mismatch until start
// - stop ignored within the start pulse
// - back-to-back writes with or without restart
// - acknowledge address and data bytes low
// - release line at ninth clock when reading
// - data line driven low only
// - address compared bitwise; eighth bit reads
// - update at acknowledge fall; aborts change nothing
// - command nibble selects target registers
// - extended command writes power-down word
module dd_dac_ctrl
	import dd_pkg::*;
#(
	parameter logic [5:0] P_ADDR_HI = 6'h2A // preset address bits, value arbitrary
)
(
	input  wire logic                 i_ref_clk,          // block clock
	input  wire logic                 i_reset,            // synchronous reset
	input  wire logic                 i_scl_clk,          // serial clock pin
	input  wire logic                 i_sda,              // data line level
	input  wire logic                 i_addr_select,      // address select pin
	output logic                      o_sda_out,          // data line drive level
	output logic                      o_sda_oe,           // data line pulled low
	output logic [`DD_CODE_W-1:0]     o_channel_a_output, // channel a code
	output logic [`DD_CODE_W-1:0]     o_channel_b_output, // channel b code
	output logic [1:0]                o_pd_mode_a,        // channel a power-down mode
	output logic [1:0]                o_pd_mode_b,        // channel b power-down mode
	output logic [1:0]                o_chan_on           // buffer on, string tied
);
	dd_bit_if bif (); // bit events from the serial domain

	// serial clock domain sampler
	dd_link_sampler u_link
	(
		.i_scl_clk (i_scl_clk),
		.i_reset   (i_reset),
		.i_sda     (i_sda),
		.bif       (bif)
	);

	logic [3:0] sync_q; // synchronised tgl, addr, sda, scl

	// pins and bit toggle into this domain
	dd_sync2 #(.W(4)) u_sync
	(
		.i_clk   (i_ref_clk),
		.i_reset (i_reset),
		.i_d     ({bif.bit_tgl, i_addr_select, i_sda, i_scl_clk}),
		.o_q     (sync_q)
	);

	logic scl_s;   // clock line level
	logic sda_s;   // data line level
	logic add_s;   // address select level
	logic tgl_s;   // bit toggle
	assign scl_s = sync_q[0];
	assign sda_s = sync_q[1];
	assign add_s = sync_q[2];
	assign tgl_s = sync_q[3];

	// edge tracking state
	logic scl_q_r;
	logic sda_q_r;
	logic tgl_q_r;
	logic start_hi_r;   // a start was seen in the current clock-high pulse
	logic scl_q_nxt;
	logic sda_q_nxt;
	logic tgl_q_nxt;
	logic start_hi_nxt;

	logic start_det;    // data falls while clock high
	logic stop_det;     // data rises while clock high
	logic scl_fall;     // clock line fell
	logic bit_ev;       // one bit caught at the clock rise
	logic bit_val;      // that bit's value
	logic [6:0] exp_addr; // own address

	assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;
	assign scl_fall  = scl_q_r & ~scl_s;
	assign bit_ev    = tgl_s ^ tgl_q_r;
	assign bit_val   = bif.bit_data;
	assign exp_addr  = {P_ADDR_HI, add_s};

	// edge tracking next values
	always_comb
	begin
		scl_q_nxt    = scl_s;
		sda_q_nxt    = sda_s;
		tgl_q_nxt    = tgl_s;
		start_hi_nxt = start_hi_r;
		if (start_det)
			start_hi_nxt = 1'b1;
		else if (scl_fall)
			start_hi_nxt = 1'b0;
	end

	// edge tracking registers; cleared like the synchroniser stages, so no false edge after reset
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			scl_q_r    <= 1'b0;
			sda_q_r    <= 1'b0;
			tgl_q_r    <= 1'b0;
			start_hi_r <= 1'b0;
		end
		else
		begin
			scl_q_r    <= scl_q_nxt;
			sda_q_r    <= sda_q_nxt;
			tgl_q_r    <= tgl_q_nxt;
			start_hi_r <= start_hi_nxt;
		end
	end

	// read-back byte: even index upper bits, odd index lower bits
	function automatic logic [7:0] rd_byte
	(
		input logic [1:0]            idx,
		input logic [`DD_CODE_W-1:0] a,
		input logic [`DD_CODE_W-1:0] b
	);
		logic [`DD_CODE_W-1:0] code;
		code = idx[1] ? b : a;
		if (idx[0])
			rd_byte = {code[`DD_UP_LSB-1:0], `DD_TAIL_PAD};
		else
			rd_byte = {`DD_RD_PAD, code[`DD_CODE_W-1:`DD_UP_LSB]};
	endfunction

	// engine state
	dd_state_type          state_r,    state_nxt;
	logic [3:0]            bitcnt_r,   bitcnt_nxt;   // bits of current word
	logic [7:0]            shreg_r,    shreg_nxt;    // received bits
	logic [7:0]            tx_r,       tx_nxt;       // byte being sent
	logic [1:0]            rd_idx_r,   rd_idx_nxt;   // next read-back byte
	logic                  rw_r,       rw_nxt;       // read selected
	logic                  byte_idx_r, byte_idx_nxt; // data byte expected
	logic                  ext_r,      ext_nxt;      // power-down word expected
	logic [3:0]            command_nibble_r,  command_nibble_nxt;
	logic [3:0]            upper_code_bits_r, upper_code_bits_nxt;
	logic [`DD_CODE_W-1:0] in_a_r,  in_a_nxt;  // input registers
	logic [`DD_CODE_W-1:0] in_b_r,  in_b_nxt;
	logic [`DD_CODE_W-1:0] dac_a_r, dac_a_nxt; // output-holding registers
	logic [`DD_CODE_W-1:0] dac_b_r, dac_b_nxt;
	logic [1:0]            pd_a_r,  pd_a_nxt;  // power-down modes
	logic [1:0]            pd_b_r,  pd_b_nxt;
	logic [1:0]            chan_on_r, chan_on_nxt;
	logic                  sda_oe_r,  sda_oe_nxt;
	logic                  sda_out_r;
	logic [`DD_CODE_W-1:0] code;    // assembled data word

	// engine next values
	always_comb
	begin
		state_nxt           = state_r;
		bitcnt_nxt          = bitcnt_r;
		shreg_nxt           = shreg_r;
		tx_nxt              = tx_r;
		rd_idx_nxt          = rd_idx_r;
		rw_nxt              = rw_r;
		byte_idx_nxt        = byte_idx_r;
		ext_nxt             = ext_r;
		command_nibble_nxt  = command_nibble_r;
		upper_code_bits_nxt = upper_code_bits_r;
		in_a_nxt            = in_a_r;
		in_b_nxt            = in_b_r;
		dac_a_nxt           = dac_a_r;
		dac_b_nxt           = dac_b_r;
		pd_a_nxt            = pd_a_r;
		pd_b_nxt            = pd_b_r;
		sda_oe_nxt          = sda_oe_r;
		code = {upper_code_bits_r, shreg_r[`DD_CMD_MSB:`DD_CMD_MSB-`DD_UP_LSB+1]};
		if (start_det)
		begin
			// start or repeated start: fresh address phase, partial word dropped
			state_nxt    = ST_ADDR;
			bitcnt_nxt   = 4'h0;
			byte_idx_nxt = 1'b0;
			ext_nxt      = 1'b0;
			sda_oe_nxt   = 1'b0;
		end
		else if (stop_det && !start_hi_r)
		begin
			// stop frees the bus; uncommitted data is lost
			state_nxt  = ST_IDLE;
			sda_oe_nxt = 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					// clock activity ignored until a start
					state_nxt = ST_IDLE;
				end
				ST_ADDR:
				begin
					if (bit_ev)
					begin
						shreg_nxt  = {shreg_r[6:0], bit_val};
						bitcnt_nxt = bitcnt_r + 4'h1;
						if (bitcnt_r == `DD_RW_BIT)
							rw_nxt = bit_val;
						else if (bit_val != exp_addr[`DD_ADDR_TOP - bitcnt_r[2:0]])
							state_nxt = ST_IDLE;
					end
					else if (scl_fall && bitcnt_r == `DD_BYTE_BITS)
					begin
						// matched: pull low for the ninth clock
						sda_oe_nxt = 1'b1;
						state_nxt  = ST_ADDR_ACK;
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						bitcnt_nxt = 4'h0;
						if (rw_r)
						begin
							// turn the line round and put out the first bit
							tx_nxt     = rd_byte(2'h0, dac_a_r, dac_b_r);
							rd_idx_nxt = 2'h1;
							sda_oe_nxt = ~tx_nxt[7];
							state_nxt  = ST_TX;
						end
						else
						begin
							sda_oe_nxt = 1'b0;
							state_nxt  = ST_RX;
						end
					end
				end
				ST_RX:
				begin
					if (bit_ev)
					begin
						shreg_nxt  = {shreg_r[6:0], bit_val};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end
					else if (scl_fall && bitcnt_r == `DD_BYTE_BITS)
					begin
						sda_oe_nxt = 1'b1;
						state_nxt  = ST_RX_ACK;
					end
				end
				ST_RX_ACK:
				begin
					if (scl_fall)
					begin
						// falling edge of the acknowledge: commit the word
						sda_oe_nxt = 1'b0;
						bitcnt_nxt = 4'h0;
						state_nxt  = ST_RX;
						if (ext_r)
						begin
							// power-down word: selected channels take the mode
							ext_nxt = 1'b0;
							if (shreg_r[`DD_PDW_SEL_A])
								pd_a_nxt = {shreg_r[`DD_PDW_SEL_HI], shreg_r[`DD_PDW_SEL_LO]};
							if (shreg_r[`DD_PDW_SEL_B])
								pd_b_nxt = {shreg_r[`DD_PDW_SEL_HI], shreg_r[`DD_PDW_SEL_LO]};
						end
						else if (!byte_idx_r)
						begin
							// command byte
							command_nibble_nxt  = shreg_r[`DD_CMD_MSB:`DD_CMD_LSB];
							upper_code_bits_nxt = shreg_r[`DD_CMD_LSB-1:0];
							if (command_nibble_nxt == `DD_CMD_UPDATE)
							begin
								// update both outputs, no data byte follows
								dac_a_nxt = in_a_r;
								dac_b_nxt = in_b_r;
							end
							else if (command_nibble_nxt == `DD_CMD_EXTENDED &&
								upper_code_bits_nxt == `DD_EXT_UPPER)
								ext_nxt = 1'b1;
							else
								byte_idx_nxt = 1'b1;
						end
						else
						begin
							// data byte completes the word
							byte_idx_nxt = 1'b0;
							case (command_nibble_r)
								`DD_CMD_LOAD_A:
								begin
									in_a_nxt  = code;
									dac_a_nxt = code;
									dac_b_nxt = in_b_r;
								end
								`DD_CMD_LOAD_B:
								begin
									in_b_nxt  = code;
									dac_b_nxt = code;
									dac_a_nxt = in_a_r;
								end
								`DD_CMD_IN_A:     in_a_nxt = code;
								`DD_CMD_IN_B:     in_b_nxt = code;
								`DD_CMD_XFER_IN_A:
								begin
									dac_a_nxt = in_a_r;
									dac_b_nxt = in_b_r;
									in_a_nxt  = code;
								end
								`DD_CMD_XFER_IN_B:
								begin
									dac_a_nxt = in_a_r;
									dac_b_nxt = in_b_r;
									in_b_nxt  = code;
								end
								`DD_CMD_LOAD_ALL:
								begin
									in_a_nxt  = code;
									in_b_nxt  = code;
									dac_a_nxt = code;
									dac_b_nxt = code;
								end
								`DD_CMD_IN_ALL:
								begin
									in_a_nxt = code;
									in_b_nxt = code;
								end
								default:
								begin
									// undefined command: acknowledged, no effect
									in_a_nxt = in_a_r;
								end
							endcase
						end
					end
				end
				ST_TX:
				begin
					if (bit_ev)
						bitcnt_nxt = bitcnt_r + 4'h1;
					else if (scl_fall && bitcnt_r == `DD_BYTE_BITS)
					begin
						sda_oe_nxt = 1'b0;
						state_nxt  = ST_TX_ACK;
					end
					else if (scl_fall && bitcnt_r != 4'h0)
					begin
						tx_nxt     = {tx_r[6:0], 1'b0};
						sda_oe_nxt = ~tx_nxt[7];
					end
				end
				ST_TX_ACK:
				begin
					if (bit_ev && bit_val)
						state_nxt = ST_IDLE;
					else if (bit_ev)
						bitcnt_nxt = `DD_ACKED_BITS;
					else if (scl_fall && bitcnt_r == `DD_ACKED_BITS)
					begin
						// acknowledged: next read-back byte
						tx_nxt     = rd_byte(rd_idx_r, dac_a_r, dac_b_r);
						rd_idx_nxt = rd_idx_r + 2'h1;
						sda_oe_nxt = ~tx_nxt[7];
						bitcnt_nxt = 4'h0;
						state_nxt  = ST_TX;
					end
				end
			endcase
		end
		chan_on_nxt = {pd_b_nxt == `DD_PD_UP, pd_a_nxt == `DD_PD_UP};
	end

	// engine registers; power-on state
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			state_r           <= ST_IDLE;
			bitcnt_r          <= 4'h0;
			shreg_r           <= 8'h00;
			tx_r              <= 8'h00;
			rd_idx_r          <= 2'h0;
			rw_r              <= 1'b0;
			byte_idx_r        <= 1'b0;
			ext_r             <= 1'b0;
			command_nibble_r  <= 4'h0;
			upper_code_bits_r <= 4'h0;
			in_a_r            <= `DD_CODE_ZERO;
			in_b_r            <= `DD_CODE_ZERO;
			dac_a_r           <= `DD_CODE_ZERO;
			dac_b_r           <= `DD_CODE_ZERO;
			pd_a_r            <= `DD_PD_100K;
			pd_b_r            <= `DD_PD_100K;
			chan_on_r         <= 2'h0;
			sda_oe_r          <= 1'b0;
			sda_out_r         <= 1'b0;
		end
		else
		begin
			state_r           <= state_nxt;
			bitcnt_r          <= bitcnt_nxt;
			shreg_r           <= shreg_nxt;
			tx_r              <= tx_nxt;
			rd_idx_r          <= rd_idx_nxt;
			rw_r              <= rw_nxt;
			byte_idx_r        <= byte_idx_nxt;
			ext_r             <= ext_nxt;
			command_nibble_r  <= command_nibble_nxt;
			upper_code_bits_r <= upper_code_bits_nxt;
			in_a_r            <= in_a_nxt;
			in_b_r            <= in_b_nxt;
			dac_a_r           <= dac_a_nxt;
			dac_b_r           <= dac_b_nxt;
			pd_a_r            <= pd_a_nxt;
			pd_b_r            <= pd_b_nxt;
			chan_on_r         <= chan_on_nxt;
			sda_oe_r          <= sda_oe_nxt;
			sda_out_r         <= 1'b0;
		end
	end

	// outputs straight from flops
	assign o_sda_out          = sda_out_r;
	assign o_sda_oe           = sda_oe_r;
	assign o_channel_a_output = dac_a_r;
	assign o_channel_b_output = dac_b_r;
	assign o_pd_mode_a        = pd_a_r;
	assign o_pd_mode_b        = pd_b_r;
	assign o_chan_on          = chan_on_r;

	// checks on the engine
	ack_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_ADDR_ACK || state_r == ST_RX_ACK) |-> sda_oe_r)
		else $error("acknowledge slot not driven low");
	rd_release_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_TX_ACK) |-> !sda_oe_r)
		else $error("line held during master acknowledge");
	idle_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_IDLE && !start_det) |=> (state_r == ST_IDLE && !sda_oe_r))
		else $error("idle engine reacted without a start");
	start_take_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		start_det |=> (state_r == ST_ADDR && bitcnt_r == 4'h0 && !sda_oe_r))
		else $error("start did not open an address phase");
	stop_free_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(stop_det && !start_hi_r) |=> (state_r == ST_IDLE && !sda_oe_r))
		else $error("stop did not free the bus");
	early_stop_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(stop_det && start_hi_r && state_r == ST_ADDR && !bit_ev) |=> state_r == ST_ADDR)
		else $error("stop inside start pulse was taken");
	addr_miss_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_ADDR && bit_ev && !start_det && !stop_det && bitcnt_r < `DD_RW_BIT &&
		bit_val != exp_addr[`DD_ADDR_TOP - bitcnt_r[2:0]]) |=> state_r == ST_IDLE)
		else $error("address mismatch not dropped");
	por_init_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$fell(i_reset) |-> (dac_a_r == `DD_CODE_ZERO && dac_b_r == `DD_CODE_ZERO &&
		pd_a_r == `DD_PD_100K && pd_b_r == `DD_PD_100K && chan_on_r == 2'h0))
		else $error("power-on state wrong");
	pd_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$changed(pd_a_r) |-> ($stable(dac_a_r) && $stable(in_a_r)))
		else $error("power-down change disturbed channel data");
	commit_ack_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$changed(dac_a_r) |-> ($past(state_r) == ST_RX_ACK && $past(scl_fall)))
		else $error("output register changed off the acknowledge fall");
	in_only_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(state_r == ST_RX_ACK && scl_fall && byte_idx_r && !ext_r && !start_det &&
		command_nibble_r == `DD_CMD_IN_A) |=> ($stable(dac_a_r) && in_a_r == $past(code)))
		else $error("input-only write misrouted");
	chan_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		chan_on_r == {pd_b_r == `DD_PD_UP, pd_a_r == `DD_PD_UP})
		else $error("channel enable disagrees with mode");
	open_drain_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		sda_oe_r |-> !sda_out_r)
		else $error("data line driven high");
endmodule

// ---- verilog/dd_params.svh ----
// constants of the dual converter two-wire control block
`ifndef DD_PARAMS_SVH
`define DD_PARAMS_SVH
`define DD_CODE_W        10
`define DD_UP_LSB        6
`define DD_CMD_MSB       7
`define DD_CMD_LSB       4
`define DD_BYTE_BITS     4'h8
`define DD_ACKED_BITS    4'h9
`define DD_RW_BIT        4'h7
`define DD_ADDR_TOP      3'h6
`define DD_CMD_LOAD_A    4'h0
`define DD_CMD_LOAD_B    4'h1
`define DD_CMD_IN_A      4'h4
`define DD_CMD_IN_B      4'h5
`define DD_CMD_XFER_IN_A 4'h8
`define DD_CMD_XFER_IN_B 4'h9
`define DD_CMD_LOAD_ALL  4'hC
`define DD_CMD_IN_ALL    4'hD
`define DD_CMD_UPDATE    4'hE
`define DD_CMD_EXTENDED  4'hF
`define DD_EXT_UPPER     4'h0
`define DD_PD_UP         2'h0
`define DD_PD_FLOAT      2'h1
`define DD_PD_1K         2'h2
`define DD_PD_100K       2'h3
`define DD_PDW_SEL_A     3
`define DD_PDW_SEL_B     2
`define DD_PDW_SEL_HI    1
`define DD_PDW_SEL_LO    0
`define DD_RD_PAD        4'h0
`define DD_TAIL_PAD      2'h0
`define DD_CODE_ZERO     10'h000
`endif

// ---- verilog/dd_pkg.sv ----
// types shared by the dual converter control block
package dd_pkg;
	// serial engine states
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} dd_state_type;
endpackage

// ---- verilog/dd_bit_if.sv ----
// per-bit hand-over from the serial clock domain to the reference domain
`timescale 1ns/1ps
interface dd_bit_if;
	logic bit_data; // data line level caught at the serial clock rise
	logic bit_tgl;  // flips once for every serial clock rise
	modport link
	(
		output bit_data,
		output bit_tgl
	);
	modport core
	(
		input bit_data,
		input bit_tgl
	);
endinterface

// ---- verilog/dd_sync2.sv ----
// two-stage level synchroniser into the reference clock domain
`timescale 1ns/1ps
module dd_sync2
#(
	parameter int W = 1
)
(
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r; // first stage, read only by the second
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// next values: plain shift through the two stages
	always_comb
	begin
		meta_nxt = i_d;
		q_nxt    = meta_r;
	end

	// register both stages
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			meta_r <= '0;
			o_q    <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			o_q    <= q_nxt;
		end
	end
endmodule

// ---- verilog/dd_link_sampler.sv ----
// serial clock domain: catches each data bit on the clock rise
`timescale 1ns/1ps
module dd_link_sampler
(
	input  wire logic i_scl_clk, // serial clock from the master
	input  wire logic i_reset,   // clears this domain without a clock edge
	input  wire logic i_sda,     // data line level
	dd_bit_if.link    bif
);
	logic data_r;   // last bit caught
	logic tgl_r;    // event toggle, one flip per rise
	logic data_nxt;
	logic tgl_nxt;

	// data is stable while the clock is high, so the rise is a safe sample point
	always_comb
	begin
		data_nxt = i_sda;
		tgl_nxt  = ~tgl_r;
	end

	// the serial clock may stand still, so reset must act without it
	always_ff @(posedge i_scl_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			data_r <= 1'b0;
			tgl_r  <= 1'b0;
		end
		else
		begin
			data_r <= data_nxt;
			tgl_r  <= tgl_nxt;
		end
	end

	// data is held for a whole clock period, long past the toggle crossing
	assign bif.bit_data = data_r;
	assign bif.bit_tgl  = tgl_r;
endmodule

// ---- verification/dd_master_model.sv ----
// two-wire bus master model: makes the serial clock, pulls data low
`timescale 1ns/1ps
module dd_master_model
(
	input  wire logic i_dev_oe, // device pulls the data line low
	output logic      o_scl,    // serial clock, still between frames
	output logic      o_sda     // resolved data line
);
	localparam time T_Q = 650ns; // quarter serial period, clock below 400 kHz
	logic drv_low;               // master pulls the data line low
	initial
	begin
		o_scl = 1'b1;
		drv_low = 1'b0;
	end
	// pull-up gives the high level when nobody pulls low
	assign o_sda = !(drv_low || i_dev_oe);
	// start or repeated start: data falls while clock is high
	task automatic start();
	begin
		drv_low = 1'b0;
		#T_Q;
		o_scl = 1'b1;
		#T_Q;
		drv_low = 1'b1;
		#T_Q;
		o_scl = 1'b0;
		#T_Q;
	end
	endtask
	// start with a stop inside the same clock-high pulse, then clock low
	task automatic start_stop();
	begin
		drv_low = 1'b0;
		#T_Q;
		o_scl = 1'b1;
		#T_Q;
		drv_low = 1'b1;
		#T_Q;
		drv_low = 1'b0;
		#T_Q;
		o_scl = 1'b0;
		#T_Q;
	end
	endtask
	// stop after at least one clock: data rises while clock is high
	task automatic stop();
	begin
		drv_low = 1'b1;
		#T_Q;
		o_scl = 1'b1;
		#T_Q;
		drv_low = 1'b0;
		#T_Q;
	end
	endtask
	// one bit: data changes only while the clock is low
	task automatic bit_x(input logic b, output logic r);
	begin
		drv_low = !b;
		#T_Q;
		o_scl = 1'b1;
		#T_Q;
		r = o_sda;
		#T_Q;
		o_scl = 1'b0;
		#T_Q;
	end
	endtask
	// eight bits msb first and the ninth acknowledge clock
	task automatic xfer(input logic [7:0] tx, input logic mack,
		output logic [7:0] rx, output logic ack);
		logic r;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(tx[i], r);
			rx[i] = r;
		end
		bit_x(!mack, r);
		ack = !r;
	end
	endtask
endmodule

// ---- verification/dual_dac_two_wire_slave_control_test.sv ----
// self-checking bench for the dual converter two-wire control block
`timescale 1ns/1ps
module dual_dac_two_wire_slave_control_test;
	localparam logic [5:0] ADDR_HI = 6'h15; // preset address bits, value arbitrary
	logic       i_ref_clk;   // block clock
	logic       i_reset;     // synchronous reset
	logic       addr_sel;    // address select pin
	logic       scl;         // serial clock
	logic       sda;         // data line
	logic       sda_oe;      // device pulls data low
	logic       sda_out;     // device drive level
	logic [9:0] out_a;       // channel a code
	logic [9:0] out_b;       // channel b code
	logic [1:0] pd_a;        // channel a mode
	logic [1:0] pd_b;        // channel b mode
	logic [1:0] chan_on;     // buffers on
	int         err_count;   // mismatches
	int         tests_run;   // comparisons
	dd_dac_ctrl #(.P_ADDR_HI(ADDR_HI)) dut
	(
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_scl_clk(scl), .i_sda(sda),
		.i_addr_select(addr_sel), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.o_channel_a_output(out_a), .o_channel_b_output(out_b),
		.o_pd_mode_a(pd_a), .o_pd_mode_b(pd_b), .o_chan_on(chan_on)
	);
	dd_master_model m (.i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda));
	initial
	begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	// compare one value and count it
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
	begin
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// outputs, modes and buffer enables against expectations
	task automatic chk_out(input logic [9:0] a, b, input logic [1:0] ma, mb);
	begin
		check(16'(out_a), 16'(a));
		check(16'(out_b), 16'(b));
		check(16'(pd_a), 16'(ma));
		check(16'(pd_b), 16'(mb));
		check(16'(chan_on), 16'({mb == 2'h0, ma == 2'h0}));
		check(16'(sda_out), 16'h0000);
	end
	endtask
	// start and address byte, expecting ack or not
	task automatic addr(input logic a0, rw, exp_ack);
		logic [7:0] rx;
		logic       ack;
	begin
		m.start();
		m.xfer({ADDR_HI, a0, rw}, 1'b0, rx, ack);
		check(16'(ack), 16'(exp_ack));
	end
	endtask
	// write byte, expecting ack
	task automatic wbyte(input logic [7:0] b);
		logic [7:0] rx;
		logic       ack;
	begin
		m.xfer(b, 1'b0, rx, ack);
		check(16'(ack), 16'h0001);
	end
	endtask
	// every command code but the extended one chained in one frame
	task automatic t_cmds();
		logic [3:0] c [9] = '{4'h0, 4'h5, 4'h4, 4'hE, 4'hC, 4'hD, 4'h8, 4'h9, 4'h1};
		logic [9:0] d [9] = '{10'h3FF, 10'h155, 10'h001, 10'h000, 10'h2AA, 10'h0F0,
			10'h123, 10'h321, 10'h200};
		logic [9:0] ea [9] = '{10'h3FF, 10'h3FF, 10'h3FF, 10'h001, 10'h2AA, 10'h2AA,
			10'h0F0, 10'h123, 10'h123};
		logic [9:0] eb [9] = '{10'h000, 10'h000, 10'h000, 10'h155, 10'h2AA, 10'h2AA,
			10'h0F0, 10'h0F0, 10'h200};
	begin
		addr(1'b0, 1'b0, 1'b1);
		for (int i = 0; i < 9; i++)
		begin
			wbyte({c[i], d[i][9:6]});
			if (c[i] != 4'hE)
				wbyte({d[i][5:0], 2'b00});
			chk_out(ea[i], eb[i], 2'h3, 2'h3);
		end
		m.stop();
	end
	endtask
	// repeated start between writes, then an aborted write
	task automatic t_restart_abort();
	begin
		addr(1'b0, 1'b0, 1'b1);
		wbyte(8'h00);
		wbyte(8'h44);
		addr(1'b0, 1'b0, 1'b1);
		wbyte(8'h10);
		wbyte(8'h88);
		addr(1'b0, 1'b0, 1'b1);
		wbyte(8'h0C);
		m.stop();
		chk_out(10'h011, 10'h022, 2'h3, 2'h3);
	end
	endtask
	// address pin and mismatch refusal
	task automatic t_pin();
	begin
		addr(1'b1, 1'b0, 1'b0);
		m.stop();
		@(negedge i_ref_clk);
		addr_sel = 1'b1;
		addr(1'b0, 1'b0, 1'b0);
		m.stop();
		addr(1'b1, 1'b0, 1'b1);
		wbyte(8'h0F);
		wbyte(8'h0C);
		m.stop();
		chk_out(10'h3C3, 10'h022, 2'h3, 2'h3);
		@(negedge i_ref_clk);
		addr_sel = 1'b0;
	end
	endtask
	// every power-down code, then one channel alone; codes retained
	task automatic t_pd();
	begin
		for (int i = 3; i >= 0; i--)
		begin
			addr(1'b0, 1'b0, 1'b1);
			wbyte(8'hF0);
			wbyte({6'h03, 2'(i)});
			m.stop();
			chk_out(10'h3C3, 10'h022, 2'(i), 2'(i));
		end
		addr(1'b0, 1'b0, 1'b1);
		wbyte(8'hF0);
		wbyte(8'h05);
		m.stop();
		chk_out(10'h3C3, 10'h022, 2'h0, 2'h1);
	end
	endtask
	// read back both channels, nack ends it
	task automatic t_read();
		logic [7:0] rx;
		logic       ack;
		logic [7:0] exp [4] = '{8'h0F, 8'h0C, 8'h00, 8'h88};
	begin
		m.start();
		m.xfer({ADDR_HI, 2'b01}, 1'b0, rx, ack);
		check(16'(ack), 16'h0001);
		for (int i = 0; i < 4; i++)
		begin
			m.xfer(8'hFF, i < 3, rx, ack);
			check(16'(rx), 16'(exp[i]));
		end
		m.stop();
	end
	endtask
	// stop inside the start pulse ignored; undefined commands change nothing
	task automatic t_early_stop();
		logic [7:0] rx;
		logic       ack;
	begin
		m.start_stop();
		m.xfer({ADDR_HI, 2'b00}, 1'b0, rx, ack);
		check(16'(ack), 16'h0001);
		wbyte(8'h10);
		wbyte(8'h44);
		wbyte(8'h2F);
		wbyte(8'hFC);
		wbyte(8'hF1);
		wbyte(8'h0C);
		m.stop();
		chk_out(10'h3C3, 10'h011, 2'h0, 2'h1);
	end
	endtask
	// counts, verdict and end of run
	task automatic conclude();
	begin
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	initial
	begin
		#3ms;
		err_count++;
		conclude();
	end
	initial
	begin
		err_count = 0;
		tests_run = 0;
		addr_sel = 1'b0;
		i_reset = 1'b1;
		repeat (5) @(negedge i_ref_clk);
		i_reset = 1'b0;
		repeat (4) @(negedge i_ref_clk);
		chk_out(10'h000, 10'h000, 2'h3, 2'h3);
		t_cmds();
		t_restart_abort();
		t_pin();
		t_pd();
		t_read();
		t_early_stop();
		conclude();
	end
endmodule
